// >>> verilog/cisr_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "cisr_regs.svh"
module cisr_status
   import cisr_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // register read port from the control interface
   input  wire logic       rd_strobe,
   input  wire cisr_addr_t rd_addr,
   output cisr_byte_t      rd_data,
   output logic            rd_valid,
   // headset event sources (levels, or pulses that span a rising clk edge, any clock)
   input  wire logic       headset_insert,
   input  wire logic       headset_remove,
   input  wire logic       headset_hook,
   // threshold and voice activity event sources
   input  wire logic       general_purpose_analog_input_high,
   input  wire logic       general_purpose_analog_input_low,
   input  wire logic       voice_activity_detector_up,
   input  wire logic       voice_activity_detector_down,
   // live clock conditions
   input  wire logic       clock_error,
   input  wire logic       pll_lock_event,
   // live channel fault conditions
   input  wire logic       input_one_fault,
   input  wire logic       input_two_fault,
   input  wire logic       output_one_fault,
   input  wire logic       output_two_fault,
   // output one terminal and driver faults
   input  wire logic       output_one_positive_terminal_short,
   input  wire logic       output_one_negative_terminal_short,
   input  wire logic       positive_driver_vgnd_fault,
   input  wire logic       negative_driver_vgnd_fault
);
   localparam int NSRC = 17;

   logic [NSRC-1:0] raw_src;
   logic [NSRC-1:0] sync_src;
   logic [6:0]      prev_reg;
   logic [6:0]      rise;

   cisr_byte_t headset_reg,   headset_next;
   cisr_byte_t threshold_reg, threshold_next;
   cisr_byte_t live_clock,    live_summary, live_out_one;
   cisr_byte_t rd_mux;

   wire hit_headset   = rd_strobe && (rd_addr == `CISR_OFS_LATCHED_HEADSET);
   wire hit_threshold = rd_strobe && (rd_addr == `CISR_OFS_LATCHED_THRESHOLD);

   // every source comes from outside the clock domain
   assign raw_src = {negative_driver_vgnd_fault, positive_driver_vgnd_fault,
                     output_one_negative_terminal_short, output_one_positive_terminal_short,
                     output_two_fault, output_one_fault, input_two_fault, input_one_fault,
                     pll_lock_event, clock_error,
                     voice_activity_detector_down, voice_activity_detector_up,
                     general_purpose_analog_input_low, general_purpose_analog_input_high,
                     headset_hook, headset_remove, headset_insert};

   cisr_sync #(.WIDTH(NSRC)) u_sync (
      .clk      (clk),
      .reset    (reset),
      .async_in (raw_src),
      .sync_out (sync_src)
   );

   // previous sample for rising-edge event detection on the latched sources
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= sync_src[6:0]; // only the latched sources need a previous sample
      end
   end

   // an event is the rising edge, so a held level latches only once
   assign rise = sync_src[6:0] & ~prev_reg[6:0];

   // latched headset bits: event sets, a read clears, set beats clear
   always_comb begin
      headset_next = hit_headset ? `CISR_RESET_VALUE : headset_reg;
      headset_next[`CISR_BIT_HS_INSERT] = headset_next[`CISR_BIT_HS_INSERT] | rise[0];
      headset_next[`CISR_BIT_HS_REMOVE] = headset_next[`CISR_BIT_HS_REMOVE] | rise[1];
      headset_next[`CISR_BIT_HS_HOOK]   = headset_next[`CISR_BIT_HS_HOOK] | rise[2];
   end

   // latched threshold and voice bits, same discipline
   always_comb begin
      threshold_next = hit_threshold ? `CISR_RESET_VALUE : threshold_reg;
      threshold_next[`CISR_BIT_GPA_HIGH]  = threshold_next[`CISR_BIT_GPA_HIGH] | rise[3];
      threshold_next[`CISR_BIT_GPA_LOW]   = threshold_next[`CISR_BIT_GPA_LOW] | rise[4];
      threshold_next[`CISR_BIT_VAD_UP]    = threshold_next[`CISR_BIT_VAD_UP] | rise[5];
      threshold_next[`CISR_BIT_VAD_DOWN]  = threshold_next[`CISR_BIT_VAD_DOWN] | rise[6];
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         headset_reg   <= `CISR_RESET_VALUE;
         threshold_reg <= `CISR_RESET_VALUE;
      end else begin
         headset_reg   <= headset_next;
         threshold_reg <= threshold_next;
      end
   end

   // live views follow the synchronised condition, nothing is held
   always_comb begin
      live_clock   = `CISR_RESET_VALUE;
      live_summary = `CISR_RESET_VALUE;
      live_out_one = `CISR_RESET_VALUE;
      live_clock[`CISR_BIT_CLK_ERROR]   = sync_src[7];
      live_clock[`CISR_BIT_PLL_LOCK]    = sync_src[8];
      live_summary[`CISR_BIT_IN_ONE]    = sync_src[9];
      live_summary[`CISR_BIT_IN_TWO]    = sync_src[10];
      live_summary[`CISR_BIT_OUT_ONE]   = sync_src[11];
      live_summary[`CISR_BIT_OUT_TWO]   = sync_src[12];
      live_out_one[`CISR_BIT_SHORT_POS] = sync_src[13];
      live_out_one[`CISR_BIT_SHORT_NEG] = sync_src[14];
      live_out_one[`CISR_BIT_VGND_POS]  = sync_src[15];
      live_out_one[`CISR_BIT_VGND_NEG]  = sync_src[16];
   end

   // read select; unmapped offsets and reserved bits read zero
   assign rd_mux = (rd_addr == `CISR_OFS_LATCHED_HEADSET)   ? headset_reg   :
                   (rd_addr == `CISR_OFS_LATCHED_THRESHOLD) ? threshold_reg :
                   (rd_addr == `CISR_OFS_LIVE_CLOCK)        ? live_clock    :
                   (rd_addr == `CISR_OFS_LIVE_SUMMARY)      ? live_summary  :
                   (rd_addr == `CISR_OFS_LIVE_OUT_ONE)      ? live_out_one  :
                   `CISR_RESET_VALUE;

   // read data registered; the value captured is the pre-clear content
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_data  <= `CISR_RESET_VALUE;
         rd_valid <= 1'b0;
      end else begin
         rd_data  <= rd_strobe ? rd_mux : rd_data;
         rd_valid <= rd_strobe;
      end
   end
endmodule // cisr_status
`default_nettype wire

// >>> verilog/cisr_regs.svh
`ifndef CISR_REGS_SVH
`define CISR_REGS_SVH

`define CISR_OFS_LATCHED_HEADSET   8'h3a
`define CISR_OFS_LATCHED_THRESHOLD 8'h3b
`define CISR_OFS_LIVE_CLOCK        8'h3c
`define CISR_OFS_LIVE_SUMMARY      8'h3d
`define CISR_OFS_LIVE_OUT_ONE      8'h40

`define CISR_RESET_VALUE           8'h00

// latched headset fields
`define CISR_BIT_HS_INSERT         3
`define CISR_BIT_HS_REMOVE         2
`define CISR_BIT_HS_HOOK           1
// latched threshold / voice fields
`define CISR_BIT_GPA_HIGH          7
`define CISR_BIT_GPA_LOW           6
`define CISR_BIT_VAD_UP            5
`define CISR_BIT_VAD_DOWN          4
// live clock fields
`define CISR_BIT_CLK_ERROR         7
`define CISR_BIT_PLL_LOCK          6
// live summary fields
`define CISR_BIT_IN_ONE            7
`define CISR_BIT_IN_TWO            6
`define CISR_BIT_OUT_ONE           5
`define CISR_BIT_OUT_TWO           4
// output one fault fields
`define CISR_BIT_SHORT_POS         7
`define CISR_BIT_SHORT_NEG         6
`define CISR_BIT_VGND_POS          5
`define CISR_BIT_VGND_NEG          4

`endif

// >>> verilog/cisr_pkg.sv
`default_nettype none
package cisr_pkg;
   typedef logic [7:0] cisr_byte_t;
   typedef logic [7:0] cisr_addr_t;
endpackage
`default_nettype wire

// >>> verilog/cisr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cisr_sync #(
   parameter int WIDTH = 4
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage_reg;

   // two flops per bit; first stage feeds only the second
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stage_reg <= '0;
         sync_out  <= '0;
      end else begin
         stage_reg <= async_in;
         sync_out  <= stage_reg;
      end
   end
endmodule // cisr_sync
`default_nettype wire

// >>> testbench/cisr_status_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cisr_status_monitor
   import cisr_pkg::*;
(
   // clock and reset
   input wire logic       clk,
   input wire logic       reset,
   // read port
   input wire logic       rd_strobe,
   input wire cisr_addr_t rd_addr,
   input wire cisr_byte_t rd_data,
   input wire logic       rd_valid,
   // live conditions
   input wire logic       clock_error,
   input wire logic       output_one_positive_terminal_short
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // handshake: one answer per request, data held between reads
   a_valid_one: assert property (rd_strobe |=> rd_valid) else $error("read not answered");
   a_no_spurious: assert property (!rd_strobe |=> !rd_valid) else $error("spurious valid");
   a_data_held: assert property (!rd_strobe |=> $stable(rd_data)) else $error("read data moved");
   // reserved bits and unmapped offsets read zero
   a_rsvd_headset: assert property (rd_strobe && rd_addr == 8'h3a |=> rd_data[7:4] == 4'h0 && !rd_data[0])
      else $error("headset reserved bits set");
   a_rsvd_thresh: assert property (rd_strobe && rd_addr == 8'h3b |=> rd_data[3:0] == 4'h0)
      else $error("threshold reserved bits set");
   a_rsvd_clock: assert property (rd_strobe && rd_addr == 8'h3c |=> rd_data[5:0] == 6'h00)
      else $error("clock reserved bits set");
   a_rsvd_fault: assert property (rd_strobe && (rd_addr == 8'h3d || rd_addr == 8'h40) |=> rd_data[3:0] == 4'h0)
      else $error("fault reserved bits set");
   a_unmapped_zero: assert property (rd_strobe && rd_addr == 8'h3e |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   // a level held through the sync delay must be visible live
   a_clock_live: assert property (clock_error[*4] ##0 (rd_strobe && rd_addr == 8'h3c) |=> rd_data[7])
      else $error("clock error not shown");
   a_short_live: assert property ((!output_one_positive_terminal_short)[*4] ##0 (rd_strobe && rd_addr == 8'h40)
      |=> !rd_data[7]) else $error("stale short shown");
   c_headset: cover property (rd_strobe && rd_addr == 8'h3a ##1 rd_data[3]);
   c_thresh: cover property (rd_strobe && rd_addr == 8'h3b ##1 rd_data[4]);
   c_live: cover property (rd_strobe && rd_addr == 8'h40 ##1 rd_data[7]);
endmodule // cisr_status_monitor
bind cisr_status cisr_status_monitor u_mon (.clk(clk), .reset(reset), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
   .rd_data(rd_data), .rd_valid(rd_valid), .clock_error(clock_error),
   .output_one_positive_terminal_short(output_one_positive_terminal_short));
`default_nettype wire

// >>> testbench/cisr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cisr_host_model
   import cisr_pkg::*;
(
   // host clock
   input  wire logic       clk,
   // read request
   output logic            rd_strobe,
   output cisr_addr_t      rd_addr
);
   // idle until the first read
   initial begin
      rd_strobe = 1'b0;
      rd_addr   = 8'h00;
   end
   // one-cycle strobe; the host only reads, so reserved bits are never written
   task automatic rd(input cisr_addr_t a);
      @(negedge clk);
      rd_strobe = 1'b1;
      rd_addr   = a;
      @(negedge clk);
      rd_strobe = 1'b0;
      rd_addr   = ~a; // scrambled so a stale offset is never relied on
   endtask
endmodule // cisr_host_model
`default_nettype wire

// >>> testbench/test_codec_interrupt_status_readback.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("wrong value %s exp %h got %h", n, e, g); end end
module test_codec_interrupt_status_readback
   import cisr_pkg::*;
;
   logic       clk = 1'b0;
   logic       reset = 1'b1;
   logic [6:0] ev = 7'h00;
   logic [9:0] lv = 10'h000;
   logic       rd_strobe, rd_valid;
   cisr_addr_t rd_addr, ra[6] = '{8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h40, 8'h3e};
   cisr_byte_t rd_data, e, exq[$];
   int         miscompares = 0, n_compared = 0;
   logic [31:0] seed = 32'h0000a2ae;
   // clock
   always #12.5 clk = ~clk;
   cisr_host_model host (.clk(clk), .rd_strobe(rd_strobe), .rd_addr(rd_addr));
   cisr_status DUT (.clk(clk), .reset(reset), .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data),
      .rd_valid(rd_valid), .headset_insert(ev[0]), .headset_remove(ev[1]), .headset_hook(ev[2]),
      .general_purpose_analog_input_high(ev[3]), .general_purpose_analog_input_low(ev[4]),
      .voice_activity_detector_up(ev[5]), .voice_activity_detector_down(ev[6]), .clock_error(lv[0]),
      .pll_lock_event(lv[1]), .input_one_fault(lv[2]), .input_two_fault(lv[3]), .output_one_fault(lv[4]),
      .output_two_fault(lv[5]), .output_one_positive_terminal_short(lv[6]),
      .output_one_negative_terminal_short(lv[7]), .positive_driver_vgnd_fault(lv[8]),
      .negative_driver_vgnd_fault(lv[9]));
   function automatic logic [31:0] xs(input logic [31:0] s);
      xs = s ^ (s << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
   endfunction
   // note the expectation, then issue the read
   task automatic rdx(input cisr_addr_t a, input cisr_byte_t x);
      exq.push_back(x);
      host.rd(a);
   endtask
   task automatic tally_and_finish;
      if (miscompares == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // compare each answer with the oldest note, away from the sampling edge
   always @(negedge clk) if (rd_valid === 1'b1) begin
      e = exq.pop_front();
      `CHK("rd_data", e, rd_data)
   end
   // main sequence: reset values, each event latched then cleared, random live levels
   initial begin
      repeat (16) @(negedge clk);
      reset = 1'b0;
      foreach (ra[k]) rdx(ra[k], 8'h00);
      for (int i = 0; i < 7; i++) begin
         ev[i] = 1'b1;
         repeat (6) @(negedge clk);
         ev[i] = 1'b0;
         rdx(i < 3 ? 8'h3a : 8'h3b, i < 3 ? 8'h08 >> i : 8'h80 >> (i - 3));
         rdx(i < 3 ? 8'h3a : 8'h3b, 8'h00); // cleared by the first read
      end
      // an event whose edge meets a clearing read stays latched for the next read
      ev[0] = 1'b1;
      @(negedge clk);
      rdx(8'h3a, 8'h00); // strobe sampled on the edge that sets the bit
      ev[0] = 1'b0;
      rdx(8'h3a, 8'h08); // set wins over the clear
      rdx(8'h3a, 8'h00);
      // a reset in mid-run drops a latched event that was never read
      ev[0] = 1'b1;
      repeat (6) @(negedge clk);
      ev[0] = 1'b0;
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      rdx(8'h3a, 8'h00);
      repeat (24) begin
         seed = xs(seed);
         lv = seed[9:0];
         repeat (4) @(negedge clk);
         rdx(8'h3c, {lv[0], lv[1], 6'h00});
         rdx(8'h3d, {lv[2], lv[3], lv[4], lv[5], 4'h0});
         rdx(8'h40, {lv[6], lv[7], lv[8], lv[9], 4'h0});
      end
      repeat (3) @(negedge clk);
      `CHK("unanswered reads", 0, exq.size())
      tally_and_finish();
   end
   // watchdog: the run needs well under a thousand cycles
   initial begin
      repeat (3000) @(posedge clk);
      miscompares++;
      tally_and_finish();
   end
endmodule // test_codec_interrupt_status_readback
`default_nettype wire
